// >>> rtl/dma_channel_transfer_control.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_transfer_control
  import dma_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  output bus_s               bus,
  input  wire logic [DW-1:0] bus_rdata,
  input  wire logic          bus_ready,
  input  wire logic [15:0]   periph_trig,
  input  wire logic          external_trigger_pin,
  input  wire logic          instr_boundary,
  input  wire logic          nmi,
  output logic               cpu_halt
);

  ////////////////////////////////////////////////////////////////////////////
  reg_s              q;
  reg_s              d;
  logic [3:0]        tsel;
  logic              trig;
  logic              arm;
  logic              level;
  logic              rep;
  logic              burst;
  logic              single;
  logic              start;
  logic              freeze;
  logic              wr_ev;
  logic              done_set;
  logic [CTRL_W-1:0] nctrl;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic [1:0]    sel,
                                         input logic          is_byte);
    logic [AW-1:0] inc;
    inc = is_byte ? ONE : TWO;
    if (sel == STEP_INC)
      step = a + inc;
    else if (sel == STEP_DEC)
      step = a - inc;
    else
      step = a;
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d        = q;
    done_set = 1'b0;
    nctrl    = hwdata[CTRL_W-1:0];
    // Only the second and third stage feed the filtered level
    d.ext_s  = {q.ext_s[1:0], external_trigger_pin};
    if (q.ext_s[1] == q.ext_s[2])
      d.ext_lvl = q.ext_s[2];
    tsel   = q.ctrl[B_TSEL+:4];
    trig   = (tsel == TSEL_SW)  ? q.ctrl[B_SWREQ] :
             (tsel == TSEL_EXT) ? q.ext_lvl : periph_trig[tsel];
    arm    = q.ctrl[B_ARM];
    level  = q.ctrl[B_LEVEL];
    rep    = q.ctrl[B_MODE+2];
    burst  = q.ctrl[B_MODE+1];
    single = (q.ctrl[B_MODE+:2] == 2'h0);
    d.trig_prev = trig;
    d.mute      = 1'b0;
    // Mute spends one cycle so a level already high is not seen as an edge
    start  = arm && !q.mute && (q.size != 16'h0000) &&
             (level ? trig : (trig && !q.trig_prev));
    freeze = level && !trig;
    wr_ev  = q.ap_v && q.ap_w;

    unique case (q.st)
      S_IDLE:
      begin
        if (start)
        begin
          d.st   = q.ctrl[B_FETCH] ? S_FETCH : S_READ;
          d.beat = 2'h0;
          if (tsel == TSEL_SW)
            d.ctrl[B_SWREQ] = 1'b0;
        end
      end
      S_FETCH:
      begin
        if (instr_boundary)
          d.st = S_READ;
      end
      S_READ:
      begin
        if (q.bus.req && bus_ready)
        begin
          d.data = q.ctrl[B_SRCB] ? {8'h00, bus_rdata[7:0]} : bus_rdata;
          d.st   = S_WRITE;
        end
        else if (wr_ev && freeze)
          d.st = S_IDLE;
      end
      S_WRITE:
      begin
        if (bus_ready)
        begin
          d.src_w = step(q.src_w, q.ctrl[B_SSTEP+:2], q.ctrl[B_SRCB]);
          d.dst_w = step(q.dst_w, q.ctrl[B_DSTEP+:2], q.ctrl[B_DSTB]);
          d.size  = q.size - ONE;
          d.beat  = q.beat + 2'h1;
          if (burst && q.beat == BURST_END)
            d.st = S_GAP;
          else if (single)
            d.st = S_IDLE;
          else
            d.st = S_READ;
          if (q.size == ONE)
          begin
            d.size   = q.size_t;
            d.src_w  = q.src_p;
            d.dst_w  = q.dst_p;
            done_set = 1'b1;
            if (!rep)
              d.ctrl[B_ARM] = 1'b0;
            if (!(burst && rep))
              d.st = S_IDLE;
          end
        end
      end
      S_GAP:
      begin
        d.gap = !q.gap;
        if (q.gap)
          d.st = S_READ;
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase

    // Abort between transfers only, never splitting a read from its write
    if ((q.st == S_GAP) || (q.st == S_FETCH) ||
        ((q.st == S_READ) && !(q.bus.req && bus_ready)))
    begin
      if (!arm)
        d.st = S_IDLE;
      if (nmi && q.ctrl[B_NMIEN])
      begin
        d.ctrl[B_ARM] = 1'b0;
        d.st          = S_IDLE;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register writes land after the engine so a software set wins
    if (wr_ev)
    begin
      unique case (q.ap_a)
        OFF_CTRL:
        begin
          d.ctrl = nctrl;
          if (!arm && nctrl[B_ARM])
          begin
            d.size_t = q.size;
            d.src_w  = q.src_p;
            d.dst_w  = q.dst_p;
            d.mute   = 1'b1;
          end
          if (nctrl[B_TSEL+:4] != tsel)
            d.mute = 1'b1;
        end
        OFF_SRC:  d.src_p = hwdata[AW-1:0];
        OFF_DST:  d.dst_p = hwdata[AW-1:0];
        OFF_SIZE:
        begin
          d.size   = hwdata[15:0];
          d.size_t = hwdata[15:0];
        end
        default:  d.ctrl = d.ctrl;
      endcase
    end
    // Hardware completion beats a clearing write in the same cycle
    if (done_set)
      d.ctrl[B_DONE] = 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // One wait state per access keeps hrdata straight from a flop
    d.hrdata = 32'h0000_0000;
    if (q.ap_v && !q.ap_w)
    begin
      unique case (q.ap_a)
        OFF_CTRL: d.hrdata = {12'h000, q.ctrl};
        OFF_SRC:  d.hrdata = {16'h0000, q.src_p};
        OFF_DST:  d.hrdata = {16'h0000, q.dst_p};
        OFF_SIZE: d.hrdata = {16'h0000, q.size};
        default:  d.hrdata = 32'h0000_0000;
      endcase
    end
    else if (!q.ap_v)
      d.hrdata = q.hrdata;
    d.ap_v      = hsel && htrans[1] && hready;
    d.ap_w      = hwrite;
    d.ap_a      = haddr[7:0];
    d.hreadyout = !d.ap_v;
    d.hresp     = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    d.bus.req      = (d.st == S_WRITE) || ((d.st == S_READ) && !freeze);
    d.bus.we       = (d.st == S_WRITE);
    d.bus.byte_sel = d.bus.we ? q.ctrl[B_DSTB] : q.ctrl[B_SRCB];
    d.bus.addr     = d.bus.we ? d.dst_w : d.src_w;
    d.bus.wdata    = q.ctrl[B_DSTB] ? {8'h00, d.data[7:0]} : d.data;
    d.cpu_halt     = d.bus.req;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q           <= '0;
      q.st        <= S_IDLE;
      q.hreadyout <= 1'b1;
    end
    else
      q <= d;
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp     = q.hresp;
  assign bus       = q.bus;
  assign cpu_halt  = q.cpu_halt;

endmodule : dma_channel_transfer_control
`default_nettype wire

// >>> rtl/dma_pkg.sv
// Behaviour
// - mode field picks single, block, burst-block, or the repeated form of each.
// - Non-repeated modes clear channel_arm on completion; repeated modes keep it set.
// - Transfer mode and address stepping are independent settings, all combinations work.
// - Source and destination width each selectable byte or word.
// - A zero transfer_count performs no transfer in any mode.
// - Pointers and count copied when channel_arm is set; working addresses step up or down.
// - Count decrements per transfer; at zero reloads and sets channel_done_flag.
// - Single mode moves exactly one unit per trigger.
// - Repeated single stays armed, one transfer per trigger, unlimited.
// - Block mode: one trigger moves the whole block; later triggers ignored.
// - Block transfer halts the CPU two cycles per transfer, then resumes.
// - Repeated block: next trigger after completion starts another block.
// - Burst-block releases the CPU two cycles after every four transfers.
// - Triggers during a running burst-block are ignored.
// - Repeated burst-block restarts without trigger until disarmed or NMI abort.
// - A trigger already present at selection does not start a transfer; with level sensing it starts one after the one mute cycle.
// - Edge sensing: a rising trigger edge starts a transfer or block.
// - Level sensing: transfers continue while trigger high and armed; works with any trigger source.
// - Level trigger low mid-block freezes; resumes on high unless registers rewritten.
// - halt_on_fetch_boundary 0 halts at once; 1 waits for instruction end.
// - Word to byte writes low byte; byte to word zeroes upper byte.
// - Selector zero: software_request triggers and clears itself when transfer starts.
package dma_pkg;

  localparam int          AW        = 16;
  localparam int          DW        = 16;
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_SRC   = 8'h04;
  localparam logic [7:0]  OFF_DST   = 8'h08;
  localparam logic [7:0]  OFF_SIZE  = 8'h0C;
  localparam int          CTRL_W    = 20;
  localparam int          B_MODE    = 0;
  localparam int          B_ARM     = 3;
  localparam int          B_SRCB    = 4;
  localparam int          B_DSTB    = 5;
  localparam int          B_SSTEP   = 6;
  localparam int          B_DSTEP   = 8;
  localparam int          B_LEVEL   = 10;
  localparam int          B_DONE    = 11;
  localparam int          B_SWREQ   = 12;
  localparam int          B_NMIEN   = 13;
  localparam int          B_FETCH   = 14;
  localparam int          B_TSEL    = 16;
  localparam logic [1:0]  STEP_DEC  = 2'h2;
  localparam logic [1:0]  STEP_INC  = 2'h3;
  localparam logic [3:0]  TSEL_SW   = 4'h0;
  localparam logic [3:0]  TSEL_EXT  = 4'hF;
  localparam logic [1:0]  BURST_END = 2'h3;
  localparam logic [15:0] ONE       = 16'h0001;
  localparam logic [15:0] TWO       = 16'h0002;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_FETCH = 5'h02,
    S_READ  = 5'h04,
    S_WRITE = 5'h08,
    S_GAP   = 5'h10
  } state_e;

  typedef struct packed {
    logic          req;
    logic          we;
    logic          byte_sel;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bus_s;

  typedef struct packed {
    state_e              st;
    logic [CTRL_W-1:0]   ctrl;
    logic [AW-1:0]       src_p;
    logic [AW-1:0]       dst_p;
    logic [15:0]         size;
    logic [15:0]         size_t;
    logic [AW-1:0]       src_w;
    logic [AW-1:0]       dst_w;
    logic [DW-1:0]       data;
    logic [1:0]          beat;
    logic                gap;
    logic                mute;
    logic                trig_prev;
    logic [2:0]          ext_s;
    logic                ext_lvl;
    logic                ap_v;
    logic                ap_w;
    logic [7:0]          ap_a;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    bus_s                bus;
    logic                cpu_halt;
  } reg_s;

endpackage : dma_pkg

// >>> tb/dma_channel_transfer_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module dma_channel_transfer_control_tb_top;
  import dma_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, bus_ready, cpu_halt, ib, stall, stl_en, ext;
  logic ib_off, nmi_in;
  logic [31:0]   haddr, hwdata, hrdata, r;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [15:0]   periph_trig;
  logic [DW-1:0] bus_rdata;
  logic [7:0]    img [256];
  bus_s          bus;
  int            error_cnt = 0, n_tests = 0, seed, halt_n = 0, h0, n;
  dma_channel_transfer_control DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus(bus), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .periph_trig(periph_trig), .external_trigger_pin(ext),
    .instr_boundary(ib), .nmi(nmi_in), .cpu_halt(cpu_halt));
  dma_mem mem (.clk(clk), .bus(bus), .stall(stall), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (cpu_halt === 1'b1)
      halt_n <= halt_n + 1;
    ib    <= !ib_off & $random(seed);
    stall <= stl_en & $random(seed);
  end
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task wt;
    int i;
    i = 0;
    while (hreadyout !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 50)
    begin
      error_cnt++;
      finish_test;
    end
  endtask : wt
  // Address phase held until ready, then data phase held until ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    wt;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    wt;
    r = hrdata;
  endtask : ahb
  task poll(input logic [7:0] a, input int b, input logic v);
    int i;
    i = 0;
    ahb(1'b0, a, 32'h0);
    while (r[b] !== v && i < 300)
    begin
      ahb(1'b0, a, 32'h0);
      i++;
    end
    if (i == 300)
    begin
      error_cnt++;
      finish_test;
    end
  endtask : poll
  task edge3;
    periph_trig[3] <= 1'b0;
    @(posedge clk);
    periph_trig[3] <= 1'b1;
  endtask : edge3
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 36;
    {rst, hsel, hwrite, haddr, htrans, hwdata, periph_trig, ext} = '0;
    {ib, stall, stl_en, ib_off, nmi_in} = '0;
    rst   = 1'b1;
    hsize = 3'h2;
    for (int k = 0; k < 256; k++)
    begin
      img[k]   = $random(seed);
      mem.m[k] = img[k];
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK(r, 32'h0)
    ahb(1'b1, 8'h30, 32'hFFFF);
    ahb(1'b0, 8'h30, 32'h0);
    `CHK(r, 32'h0)
    // Single word transfers with a stalling memory
    stl_en = 1'b1;
    ahb(1'b1, OFF_SRC, 32'h20);
    ahb(1'b1, OFF_DST, 32'h40);
    ahb(1'b1, OFF_SIZE, 32'h2);
    ahb(1'b1, OFF_CTRL, 32'h3C8);
    for (int t = 0; t < 2; t++)
    begin
      ahb(1'b1, OFF_CTRL, 32'h13C8);
      if (t == 0)
        poll(OFF_SIZE, 0, 1'b1);
      else
        poll(OFF_CTRL, B_ARM, 1'b0);
      `CHK({mem.m[8'h41 + 2 * t], mem.m[8'h40 + 2 * t]}, {img[8'h21 + 2 * t], img[8'h20 + 2 * t]})
    end
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK(r[B_DONE], 1'b1)
    `CHK(r[B_SWREQ], 1'b0)
    ahb(1'b0, OFF_SIZE, 32'h0);
    `CHK(r, 32'h2)
    stl_en = 1'b0;
    // Zero count in every mode
    ahb(1'b1, OFF_SIZE, 32'h0);
    for (int md = 0; md < 8; md++)
    begin
      h0 = halt_n;
      ahb(1'b1, OFF_CTRL, 32'h8 | md);
      ahb(1'b1, OFF_CTRL, 32'h1008 | md);
      repeat (20) @(posedge clk);
      `CHK(halt_n - h0, 0)
    end
    ahb(1'b1, OFF_CTRL, 32'h0);
    // Repeated block, byte to word, trigger already high when armed
    n = 3 + ($random(seed) & 3);
    ahb(1'b1, OFF_SRC, 32'h10);
    ahb(1'b1, OFF_DST, 32'h80);
    ahb(1'b1, OFF_SIZE, n);
    periph_trig[3] <= 1'b1;
    h0 = halt_n;
    ahb(1'b1, OFF_CTRL, 32'h303DD);
    repeat (20) @(posedge clk);
    `CHK(halt_n - h0, 0)
    edge3;
    repeat (4) @(posedge clk);
    edge3;
    repeat (2 * n + 20) @(posedge clk);
    `CHK(halt_n - h0, 2 * n)
    for (int k = 0; k < n; k++)
      `CHK({mem.m[8'h81 + 2 * k], mem.m[8'h80 + 2 * k]}, {8'h00, img[8'h10 + k]})
    edge3;
    repeat (2 * n + 20) @(posedge clk);
    `CHK(halt_n - h0, 4 * n)
    ahb(1'b1, OFF_CTRL, 32'h0);
    // Burst-block of eight words
    ahb(1'b1, OFF_SIZE, 32'h8);
    h0 = halt_n;
    ahb(1'b1, OFF_CTRL, 32'h303CA);
    edge3;
    poll(OFF_CTRL, B_ARM, 1'b0);
    `CHK(halt_n - h0, 16)
    // Level trigger on the pin: freeze while low, resume when high
    ahb(1'b1, OFF_SIZE, 32'h6);
    h0 = halt_n;
    ahb(1'b1, OFF_CTRL, 32'hF07C9);
    ext <= 1'b1;
    repeat (9) @(posedge clk);
    ext <= 1'b0;
    repeat (8) @(posedge clk);
    n = halt_n - h0;
    repeat (20) @(posedge clk);
    `CHK(halt_n - h0, n)
    `CHK(n > 0 && n < 12, 1'b1)
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK(r[B_ARM], 1'b1)
    ext <= 1'b1;
    poll(OFF_CTRL, B_ARM, 1'b0);
    `CHK(halt_n - h0, 12)
    ext <= 1'b0;
    // Halt waits for an instruction boundary
    ahb(1'b1, OFF_SIZE, 32'h1);
    ib_off = 1'b1;
    h0 = halt_n;
    ahb(1'b1, OFF_CTRL, 32'h43C8);
    ahb(1'b1, OFF_CTRL, 32'h53C8);
    repeat (20) @(posedge clk);
    `CHK(halt_n - h0, 0)
    ib_off = 1'b0;
    repeat (20) @(posedge clk);
    `CHK(halt_n - h0, 2)
    // Repeated burst restarts by itself until an NMI aborts it
    ahb(1'b1, OFF_SIZE, 32'h8);
    h0 = halt_n;
    ahb(1'b1, OFF_CTRL, 32'h23CE);
    ahb(1'b1, OFF_CTRL, 32'h33CE);
    repeat (60) @(posedge clk);
    `CHK(halt_n - h0 > 16, 1'b1)
    nmi_in <= 1'b1;
    poll(OFF_CTRL, B_ARM, 1'b0);
    nmi_in <= 1'b0;
    h0 = halt_n;
    repeat (20) @(posedge clk);
    `CHK(halt_n - h0, 0)
    finish_test;
  end
endmodule : dma_channel_transfer_control_tb_top
bind dma_channel_transfer_control dma_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .bus(bus), .bus_rdata(bus_rdata),
  .bus_ready(bus_ready), .cpu_halt(cpu_halt));
`default_nettype wire

// >>> tb/dma_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dma_chk
  import dma_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          hsel,
  input wire logic [1:0]    htrans,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire bus_s          bus,
  input wire logic [DW-1:0] bus_rdata,
  input wire logic          bus_ready,
  input wire logic          cpu_halt
);
  logic [DW-1:0] rd_q;
  logic          rdb_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Last accepted read, so each write can be tied to its own source unit
  always_ff @(posedge clk)
  begin
    if (bus.req && !bus.we && bus_ready)
    begin
      rd_q  <= bus_rdata;
      rdb_q <= bus.byte_sel;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_halt; cpu_halt == bus.req; endproperty
  a_halt: assert property (p_halt)
    else $error("halt differs from bus request");
  property p_hold; bus.req && !bus_ready |=> bus.req && $stable(bus.addr) && $stable(bus.we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before accept");
  property p_rdwr; bus.req && !bus.we && bus_ready |=> bus.req && bus.we; endproperty
  a_rdwr: assert property (p_rdwr)
    else $error("read not followed by write");
  property p_one; bus.req && bus.we && bus_ready |=> !(bus.req && bus.we); endproperty
  a_one: assert property (p_one)
    else $error("second write for one read");
  property p_low; bus.req && bus.we |-> bus.wdata[7:0] == rd_q[7:0]; endproperty
  a_low: assert property (p_low)
    else $error("low byte not copied");
  property p_up; bus.req && bus.we && rdb_q && !bus.byte_sel |-> bus.wdata[15:8] == 8'h00;
  endproperty
  a_up: assert property (p_up)
    else $error("upper byte not cleared");
  property p_word; bus.req && bus.we && !rdb_q && !bus.byte_sel |-> bus.wdata == rd_q;
  endproperty
  a_word: assert property (p_word)
    else $error("word not copied whole");
  property p_ahb; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
  a_ahb: assert property (p_ahb)
    else $error("register access timing wrong");
endmodule : dma_chk
`default_nettype wire

// >>> tb/dma_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dma_mem
  import dma_pkg::*;
(
  input wire logic      clk,
  input wire bus_s      bus,
  input wire logic      stall,
  output logic [DW-1:0] bus_rdata,
  output logic          bus_ready
);
  logic [7:0]    m [256];
  logic [DW-1:0] last_q = '0;
  logic [7:0]    a;
  assign a         = bus.addr[7:0];
  assign bus_ready = !stall;
  // Idle lines show the inverse of the last value; byte reads leave junk on top
  always_comb
  begin
    if (bus.req && !bus.we)
      bus_rdata = bus.byte_sel ? {~m[a], m[a]} : {m[a + 8'h01], m[a]};
    else
      bus_rdata = ~last_q;
  end
  always @(posedge clk)
  begin
    if (bus.req && bus_ready && !bus.we)
      last_q <= bus_rdata;
    if (bus.req && bus_ready && bus.we)
    begin
      m[a] <= bus.wdata[7:0];
      if (!bus.byte_sel)
        m[a + 8'h01] <= bus.wdata[15:8];
    end
  end
endmodule : dma_mem
`default_nettype wire
